//--- core/overflow_device_pci_header.sv
// configuration header of the overflow function: command, status, ids and window base
// assumes a byte-wide config port on sys_clk, strobes one cycle and never together
//
// Local design decision: the strobed register port.
`include "ovf_defines.svh"
`default_nettype none
module overflow_device_pci_header
  import ovf_pkg::*;
#(
  parameter logic PREFETCHABLE = 1'b0
) (
  input  wire logic        sys_clk,
  input  wire logic        rst,
  input  wire logic [7:0]  cfg_addr,
  input  wire logic [7:0]  cfg_wdata,
  input  wire logic        cfg_wr,
  input  wire logic        cfg_rd,
  output logic      [7:0]  cfg_rdata,
  input  wire logic [7:0]  primary_revision,
  input  wire logic [31:0] mem_addr,
  input  wire logic        mem_req,
  output logic             mem_hit,
  input  wire logic [15:0] io_addr,
  input  wire logic        io_req,
  input  wire logic [15:0] io_range_low,
  input  wire logic [15:0] io_range_high,
  output logic             io_hit,
  output logic             memory_space_enable,
  output logic             io_space_enable,
  output logic      [31:0] window_base_address
);

  logic [15:0]  function_command_q;
  logic [15:0]  function_status;
  logic [7:0]   revision_number_q;
  logic [31:0]  window_base_q;
  logic [7:0]   cfg_rdata_q;
  logic [7:0]   rd_byte;
  logic [31:0]  bar_word;
  reg_sel_e     wr_sel;
  reg_sel_e     rd_sel;

  decode_if dec ();

  // shared by the write and read paths so both agree on the map
  function automatic reg_sel_e sel_of(input logic [7:0] a);
    reg_sel_e s;
    s = SEL_RSVD;
    case (a)
      `OVF_CMD_LO_OFS, `OVF_CMD_HI_OFS: s = SEL_CMD;
      `OVF_STS_LO_OFS, `OVF_STS_HI_OFS: s = SEL_STS;
      `OVF_REV_OFS:                     s = SEL_REV;
      `OVF_SUB_CLASS_FIELD_OFS:                    s = SEL_SUB_CLASS_FIELD;
      `OVF_BCC_OFS:                     s = SEL_BCC;
      `OVF_HDR_OFS:                     s = SEL_HDR;
      `OVF_BAR_B0_OFS, `OVF_BAR_B1_OFS,
      `OVF_BAR_B2_OFS, `OVF_BAR_B3_OFS: s = SEL_BAR;
      default:                          s = SEL_RSVD;
    endcase
    return s;
  endfunction

  assign wr_sel = cfg_wr ? sel_of(cfg_addr) : SEL_NONE;
  assign rd_sel = cfg_rd ? sel_of(cfg_addr) : SEL_NONE;

  // command word: only the two enables hold state
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      function_command_q <= `OVF_CMD_RESET;
    end else if (wr_sel == SEL_CMD && cfg_addr == `OVF_CMD_LO_OFS) begin
      function_command_q[`OVF_CMD_MEM_BIT] <= cfg_wdata[`OVF_CMD_MEM_BIT];
      function_command_q[`OVF_CMD_IO_BIT]  <= cfg_wdata[`OVF_CMD_IO_BIT];
    end
  end
  // status is fixed; writes to it fall through to nothing
  always_comb begin
    function_status = `OVF_STS_RESET;
  end

  // revision follows the primary function continuously
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      revision_number_q <= `OVF_REV_RESET;
    end else begin
      revision_number_q <= primary_revision;
    end
  end

  // base bits per byte lane; low lane and low nibble of lane 1 are fixed
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      window_base_q <= `OVF_BAR_RESET;
    end else if (wr_sel == SEL_BAR) begin
      case (cfg_addr)
        `OVF_BAR_B1_OFS: window_base_q[15:12] <= cfg_wdata[7:4];
        `OVF_BAR_B2_OFS: window_base_q[23:16] <= cfg_wdata;
        `OVF_BAR_B3_OFS: window_base_q[31:24] <= cfg_wdata;
        default:         window_base_q        <= window_base_q;
      endcase
    end
  end

  function automatic logic [31:0] bar_view(input logic [31:0] b);
    logic [31:0] v;
    v = 32'h0000_0000;
    v[31:12] = b[31:12];
    v[`OVF_BAR_PREF_BIT] = PREFETCHABLE;
    return v;
  endfunction

  // one view feeds both the read lanes and the output port
  assign bar_word = bar_view(window_base_q);

  // read mux: reserved offsets and unused command and base bits read zero
  always_comb begin
    rd_byte = `OVF_ZERO_BYTE;
    case (rd_sel)
      SEL_CMD: begin
        if (cfg_addr == `OVF_CMD_LO_OFS) begin
          rd_byte = {6'b00_0000, function_command_q[1:0]};
        end else begin
          rd_byte = `OVF_ZERO_BYTE;
        end
      end
      SEL_STS: begin
        if (cfg_addr == `OVF_STS_LO_OFS) begin
          rd_byte = function_status[7:0];
        end else begin
          rd_byte = function_status[15:8];
        end
      end
      SEL_REV:  rd_byte = revision_number_q;
      SEL_SUB_CLASS_FIELD: rd_byte = `OVF_SUB_CLASS_FIELD_VALUE;
      SEL_BCC:  rd_byte = `OVF_BCC_VALUE;
      SEL_HDR:  rd_byte = `OVF_HDR_VALUE;
      SEL_BAR:  rd_byte = bar_word[{cfg_addr[1:0], 3'b000} +: 8];
      SEL_RSVD: rd_byte = `OVF_ZERO_BYTE;
      SEL_NONE: rd_byte = `OVF_ZERO_BYTE;
      default:  rd_byte = `OVF_ZERO_BYTE;
    endcase
  end

  // data valid only in the cycle after the strobe
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      cfg_rdata_q <= `OVF_ZERO_BYTE;
    end else begin
      cfg_rdata_q <= rd_byte;
    end
  end
  assign cfg_rdata = cfg_rdata_q;

  assign dec.memory_space_enable = function_command_q[`OVF_CMD_MEM_BIT];
  assign dec.io_space_enable     = function_command_q[`OVF_CMD_IO_BIT];
  assign dec.window_base         = window_base_q[31:12];
  assign dec.mem_addr            = mem_addr;
  assign dec.mem_req             = mem_req;
  assign dec.io_addr             = io_addr;
  assign dec.io_range_low        = io_range_low;
  assign dec.io_range_high       = io_range_high;
  assign dec.io_req              = io_req;

  window_decoder u_window (
    .dec (dec.win)
  );

  io_range_decoder u_io (
    .dec (dec.io)
  );

  assign mem_hit             = dec.mem_hit;
  assign io_hit              = dec.io_hit;
  assign memory_space_enable = function_command_q[`OVF_CMD_MEM_BIT];
  assign io_space_enable     = function_command_q[`OVF_CMD_IO_BIT];
  assign window_base_address = bar_word;

endmodule
`default_nettype wire

//--- core/ovf_defines.svh
// overflow function configuration header: offsets, field positions, reset values
// assumes byte-addressed configuration port with 8-bit data, included by bare name
`ifndef OVF_DEFINES_SVH
`define OVF_DEFINES_SVH

`define OVF_CMD_LO_OFS      8'h04
`define OVF_CMD_HI_OFS      8'h05
`define OVF_STS_LO_OFS      8'h06
`define OVF_STS_HI_OFS      8'h07
`define OVF_REV_OFS         8'h08
`define OVF_SUB_CLASS_FIELD_OFS        8'h0a
`define OVF_BCC_OFS         8'h0b
`define OVF_HDR_OFS         8'h0e
`define OVF_BAR_B0_OFS      8'h10
`define OVF_BAR_B1_OFS      8'h11
`define OVF_BAR_B2_OFS      8'h12
`define OVF_BAR_B3_OFS      8'h13

`define OVF_CMD_IO_BIT      0
`define OVF_CMD_MEM_BIT     1
`define OVF_CMD_RESET       16'h0000
`define OVF_STS_RESET       16'h0080
`define OVF_SUB_CLASS_FIELD_VALUE      8'h80
`define OVF_BCC_VALUE       8'h08
`define OVF_HDR_VALUE       8'h00
`define OVF_BAR_RESET       32'h0000_0000
`define OVF_BAR_BASE_LSB    12
`define OVF_BAR_BASE_W      20
`define OVF_BAR_PREF_BIT    3
`define OVF_BAR_B1_WMASK    8'hf0
`define OVF_REV_RESET       8'h00
`define OVF_ZERO_BYTE       8'h00

`endif

//--- core/ovf_pkg.sv
// types shared by the overflow configuration header and its decoders
// assumes nothing beyond the defines header
`default_nettype none
package ovf_pkg;
  typedef enum logic [8:0] {
    SEL_NONE = 9'b0_0000_0001,
    SEL_CMD  = 9'b0_0000_0010,
    SEL_STS  = 9'b0_0000_0100,
    SEL_REV  = 9'b0_0000_1000,
    SEL_SUB_CLASS_FIELD = 9'b0_0001_0000,
    SEL_BCC  = 9'b0_0010_0000,
    SEL_HDR  = 9'b0_0100_0000,
    SEL_BAR  = 9'b0_1000_0000,
    SEL_RSVD = 9'b1_0000_0000
  } reg_sel_e;
  typedef logic [19:0] window_base_t;
endpackage
`default_nettype wire

//--- core/decode_if.sv
// decode carrier between the register bank and its window and io decoders
// assumes all parties on sys_clk
`default_nettype none
interface decode_if;
  logic        memory_space_enable;
  logic        io_space_enable;
  logic [19:0] window_base;
  logic [31:0] mem_addr;
  logic        mem_req;
  logic        mem_hit;
  logic [15:0] io_addr;
  logic [15:0] io_range_low;
  logic [15:0] io_range_high;
  logic        io_req;
  logic        io_hit;
  modport bank (output memory_space_enable, io_space_enable, window_base, mem_addr, mem_req,
                output io_addr, io_range_low, io_range_high, io_req, input mem_hit, io_hit);
  modport win  (input memory_space_enable, window_base, mem_addr, mem_req, output mem_hit);
  modport io   (input io_space_enable, io_addr, io_range_low, io_range_high, io_req, output io_hit);
endinterface
`default_nettype wire

//--- core/window_decoder.sv
// claims memory accesses that fall in the 4 KB window
// assumes address and request come from logic on the same clock
`default_nettype none
module window_decoder (
  decode_if.win dec
);
  // 4 KB window: only the base bits take part in the compare
  assign dec.mem_hit = dec.mem_req & dec.memory_space_enable &
                       (dec.mem_addr[31:12] == dec.window_base);
endmodule
`default_nettype wire

//--- core/io_range_decoder.sv
// decodes the io range held by the companion bridge registers
// assumes low and high bounds are inclusive and steady during a request
`default_nettype none
module io_range_decoder (
  decode_if.io dec
);
  assign dec.io_hit = dec.io_req & dec.io_space_enable &
                      (dec.io_addr >= dec.io_range_low) &
                      (dec.io_addr <= dec.io_range_high);
endmodule
`default_nettype wire

//--- tb/ovf_props.sv
// concurrent checks on the overflow config header ports
// assumes one sys_clk domain and a synchronous active-high rst
`default_nettype none
module ovf_props (
  input wire logic        sys_clk,
  input wire logic        rst,
  input wire logic [7:0]  cfg_addr,
  input wire logic [7:0]  cfg_wdata,
  input wire logic        cfg_wr,
  input wire logic        cfg_rd,
  input wire logic [7:0]  cfg_rdata,
  input wire logic [31:0] mem_addr,
  input wire logic        mem_req,
  input wire logic        mem_hit,
  input wire logic [15:0] io_addr,
  input wire logic        io_req,
  input wire logic [15:0] io_range_low,
  input wire logic [15:0] io_range_high,
  input wire logic        io_hit,
  input wire logic        memory_space_enable,
  input wire logic        io_space_enable,
  input wire logic [31:0] window_base_address
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  sequence s_rd(a);
    cfg_rd && cfg_addr == a;
  endsequence
  sequence s_wr(a);
    cfg_wr && cfg_addr == a;
  endsequence
  a_mem_claim: assert property (mem_hit == (mem_req && memory_space_enable &&
    mem_addr[31:12] == window_base_address[31:12])) else $error("mem_hit wrong");
  a_io_claim: assert property (io_hit == (io_req && io_space_enable &&
    io_addr >= io_range_low && io_addr <= io_range_high)) else $error("io_hit wrong");
  a_bar_fixed: assert property (window_base_address[11:4] == 8'h00 &&
    window_base_address[2:0] == 3'h0) else $error("base low bits wrong");
  a_cmd_write: assert property (s_wr(8'h04) |=> memory_space_enable == $past(cfg_wdata[1]) &&
    io_space_enable == $past(cfg_wdata[0])) else $error("enables not written");
  a_enable_hold: assert property (!cfg_wr |=> $stable(memory_space_enable) &&
    $stable(io_space_enable)) else $error("enables moved");
  a_base_write: assert property (s_wr(8'h13) |=>
    window_base_address[31:24] == $past(cfg_wdata)) else $error("base top byte");
  a_rdata_idle: assert property (!$past(cfg_rd) |-> cfg_rdata == 8'h00) else $error("rdata idle");
  a_status_low: assert property (s_rd(8'h06) |=> cfg_rdata == 8'h80) else $error("status low");
  a_cmd_high: assert property (s_rd(8'h05) |=> cfg_rdata == 8'h00) else $error("command high");
endmodule
bind overflow_device_pci_header ovf_props u_props (.sys_clk, .rst, .cfg_addr, .cfg_wdata, .cfg_wr,
  .cfg_rd, .cfg_rdata, .mem_addr, .mem_req, .mem_hit, .io_addr, .io_req, .io_range_low,
  .io_range_high, .io_hit, .memory_space_enable, .io_space_enable, .window_base_address);
`default_nettype wire

//--- tb/tb_overflow_device_pci_header.sv
// self-checking bench for the overflow config header
// assumes the header, its package and the checker are compiled first
`default_nettype none
module tb_overflow_device_pci_header;
  timeunit 1ns;
  timeprecision 1ns;
  logic        sys_clk = 1'b0, rst = 1'b1, cfg_wr = 1'b0, cfg_rd = 1'b0, mem_req = 1'b0, io_req = 1'b0;
  logic        mem_hit, io_hit, memory_space_enable, io_space_enable;
  logic [7:0]  cfg_addr = 8'h00, cfg_wdata = 8'h00, cfg_rdata, primary_revision = 8'h5a;
  logic [15:0] io_addr = 16'h0000, io_range_low = 16'h0100, io_range_high = 16'h01ff;
  logic [31:0] mem_addr = 32'h0000_0000, window_base_address;
  int          err_total = 0, tests_run = 0;
  always #10 sys_clk = ~sys_clk;
  overflow_device_pci_header dut (.sys_clk, .rst, .cfg_addr, .cfg_wdata, .cfg_wr, .cfg_rd,
    .cfg_rdata, .primary_revision, .mem_addr, .mem_req, .mem_hit, .io_addr, .io_req,
    .io_range_low, .io_range_high, .io_hit, .memory_space_enable, .io_space_enable,
    .window_base_address);
  task automatic chk(input string what, input logic [31:0] exp, got);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, d);
    @(posedge sys_clk);
    cfg_wr <= 1'b1;
    cfg_addr <= a;
    cfg_wdata <= d;
    @(posedge sys_clk);
    cfg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, exp);
    @(posedge sys_clk);
    cfg_rd <= 1'b1;
    cfg_addr <= a;
    @(posedge sys_clk);
    cfg_rd <= 1'b0;
    #1 chk("cfg_rdata", {24'h0, exp}, {24'h0, cfg_rdata});
  endtask
  // requests held over one edge so decode is judged on settled enables
  task automatic hits(input logic [31:0] ma, input logic [15:0] ia, input logic em, ei);
    @(posedge sys_clk);
    mem_addr <= ma;
    io_addr <= ia;
    mem_req <= 1'b1;
    io_req <= 1'b1;
    @(posedge sys_clk);
    #1 chk("mem_hit", {31'h0, em}, {31'h0, mem_hit});
    chk("io_hit", {31'h0, ei}, {31'h0, io_hit});
  endtask
  task automatic t_defaults;
    logic [15:0] t[15] = '{16'h0400, 16'h0500, 16'h0680, 16'h0700, 16'h085a, 16'h0900, 16'h0a80,
      16'h0b08, 16'h0c00, 16'h0e00, 16'h1000, 16'h1100, 16'h1200, 16'h1300, 16'h1400};
    for (int i = 0; i < 15; i++)
      rd(t[i][15:8], t[i][7:0]);
    chk("window_base_address", 32'h0000_0000, window_base_address);
  endtask
  task automatic t_write_back;
    logic [23:0] t[15] = '{24'h04_ff03, 24'h05_ff00, 24'h06_ff80, 24'h07_ff00, 24'h08_005a,
      24'h0a_0080, 24'h0b_0008, 24'h0e_ff00, 24'h09_ff00, 24'h10_ff00, 24'h11_fff0,
      24'h12_ffff, 24'h13_ffff, 24'h04_0202, 24'h04_0101};
    for (int i = 0; i < 15; i++) begin
      wr(t[i][23:16], t[i][15:8]);
      rd(t[i][23:16], t[i][7:0]);
    end
    chk("enables", 32'h1, {30'h0, memory_space_enable, io_space_enable});
    chk("window_base_address", 32'hffff_f000, window_base_address);
  endtask
  task automatic t_decode;
    wr(8'h13, 8'h12);
    wr(8'h12, 8'h34);
    wr(8'h11, 8'h50);
    hits(32'h1234_5abc, 16'h01ff, 1'b0, 1'b1);
    hits(32'h1234_5abc, 16'h0200, 1'b0, 1'b0);
    wr(8'h04, 8'h02);
    hits(32'h1234_5fff, 16'h0100, 1'b1, 1'b0);
    hits(32'h1234_6000, 16'h0150, 1'b0, 1'b0);
  endtask
  task automatic t_reset;
    @(posedge sys_clk);
    rst <= 1'b1;
    repeat (2) @(posedge sys_clk);
    rst <= 1'b0;
    #1 chk("window_base_address", 32'h0000_0000, window_base_address);
    chk("enables", 32'h0, {30'h0, memory_space_enable, io_space_enable});
    rd(8'h04, 8'h00);
    // a moving primary revision tells a mirror from a constant
    primary_revision <= 8'ha5;
    rd(8'h08, 8'ha5);
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge sys_clk);
    rst <= 1'b0;
    t_defaults();
    t_write_back();
    t_decode();
    t_reset();
    close_out();
  end
  // tests need about 125 cycles
  initial begin
    repeat (3000) @(posedge sys_clk);
    err_total++;
    close_out();
  end
endmodule
`default_nettype wire
